// [include/fsir_defs.svh]
// Purpose: register indices, field positions and reset values of the
//          flash status and interrupt register bank
// Assumes: register byte address is four times the index
// Notes:   definitions only
`ifndef FSIR_DEFS_SVH
`define FSIR_DEFS_SVH

// register indices
`define FSIR_IDX_CSW 16'hF240
`define FSIR_IDX_INTF 16'hF241
`define FSIR_IDX_CFG 16'hF250
`define FSIR_IDX_EVT 16'hF251
`define FSIR_IDX_MASK 16'hF252

// interrupt_flags field positions
`define FSIR_INTF_MASTER 15
`define FSIR_INTF_LOAD 7
`define FSIR_INTF_PROG 6
`define FSIR_INTF_ERASE 5
`define FSIR_INTF_RST 4

// reset values
`define FSIR_INTF_COLD 16'h8080
`define FSIR_INTF_WARM 16'h8010
`define FSIR_CFG_RESET 16'h0001
`define FSIR_MASK_RESET 4'h0

// ecc result codes
`define FSIR_ECC_NONE 2'h0
`define FSIR_ECC_UNCORR 2'h2

// command codes
`define FSIR_CMD_LOAD_A 16'h0000
`define FSIR_CMD_LOAD_B 16'h0013
`define FSIR_CMD_PROG_A 16'h0080
`define FSIR_CMD_PROG_B 16'h001A
`define FSIR_CMD_PROG_C 16'h001B
`define FSIR_CMD_ERASE_A 16'h0094
`define FSIR_CMD_ERASE_B 16'h0095
`define FSIR_CMD_ERASE_C 16'h0030
`define FSIR_CMD_RST_A 16'h00B0
`define FSIR_CMD_RST_B 16'h00F0
`define FSIR_CMD_RST_C 16'h00F3
`define FSIR_CMD_MISC_A 16'h0065
`define FSIR_CMD_MISC_B 16'h0023
`define FSIR_CMD_MISC_C 16'h0071
`define FSIR_CMD_MISC_D 16'h002A
`define FSIR_CMD_MISC_E 16'h002C

`endif

// [include/fsir_pkg.sv]
// Purpose: types shared by the flash status and interrupt register bank
// Assumes: nothing
// Notes:   constants live in fsir_defs.svh
package fsir_pkg;

    // operation class of the running command
    typedef enum logic [2:0] {
        CLS_NONE,
        CLS_LOAD,
        CLS_PROG,
        CLS_ERASE,
        CLS_RESET,
        CLS_MISC
    } fsir_cls_type;

    // controller sequencing state
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_RESETTING
    } fsir_state_type;

    // operation events from the flash controller core
    typedef struct packed {
        logic start;
        logic [15:0] cmd;
        logic load_other;
        logic otp_target;
        logic done;
        logic fail;
        logic ecc_main_bad;
        logic ecc_spare_bad;
        logic suspend;
    } fsir_op_type;

    // classic wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [17:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } fsir_wb_req_type;

    // controller_state_word in bit order
    typedef struct packed {
        logic ongo;
        logic lock;
        logic load;
        logic prog;
        logic erase;
        logic error;
        logic sus;
        logic rsvd8;
        logic reset_busy_flag;
        logic otp_lock_flag;
        logic [4:0] rsvd;
        logic expiry_flag;
    } fsir_csw_type;

endpackage : fsir_pkg

// [hw/fsir_flag.sv]
// Purpose: one sticky status flag with load, set and clear
// Assumes: set wins over clear, load wins over both
// Notes:   load models the hardware reset sequences
module fsir_flag #(
    parameter logic COLD_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // flag control
    input wire logic set_in,
    input wire logic clr_in,
    input wire logic load_in,
    input wire logic load_val_in,
    // flag value
    output logic q_out
);

    logic q_r;
    logic q_nxt;

    // next flag value, set wins over clear
    always_comb
    begin
        q_nxt = q_r;
        if (load_in)
        begin
            q_nxt = load_val_in;
        end
        else if (set_in)
        begin
            q_nxt = 1'b1;
        end
        else if (clr_in)
        begin
            q_nxt = 1'b0;
        end
    end

    // flag register
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            q_r <= COLD_VAL;
        end
        else if (ce_in)
        begin
            q_r <= q_nxt;
        end
    end

    assign q_out = q_r;

    AST_FLAG_SET_WINS: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        ce_in && set_in && !load_in |=> q_r)
        else $error("flag lost a set against a clear");

endmodule : fsir_flag

// [hw/fsir_regs.sv]
// Purpose: controller status word and interrupt flags of a flash device,
//          reached over a classic wishbone slave
// Assumes: operation events are synchronous to ref_clk_in
// Notes:   rst_b_in is the cold reset; warm and hot resets are inputs
//
// Local design decision: the Wishbone register port.
`include "fsir_defs.svh"

// Overview of operation
// - reset-busy bit 7 high during reset
// - bit 6 shows otp lock, default unlocked
// - locked otp refuses program and erase
// - otp lock captured at power-on automatically
// - expiry bit 0 always zero
// - busy plus class bit; fail keeps class, error; reset commands ignore fail
// - load fail with bad ecc sets uncorrectable ecc code
// - load reset shows load, error, reset-busy
// - master flag bit 15 above completion flags
// - interrupt pin follows master flag and polarity
// - cold 8080h, warm or hot 8010h
// - master set by completions or misc commands
// - master cleared by write 0 or warm or hot reset
// - load flag set on load completion
// - program flag set on program completion
// - erase flag set on erase completion
// - reset flag set, cleared only by host or cold reset
module fsir_regs #(
    parameter int ADR_W = 18
) (
    // clock, reset, enable
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    // warm and hot reset levels
    input wire logic warm_rst_in,
    input wire logic hot_rst_in,
    // controller core
    input wire fsir_pkg::fsir_op_type op_in,
    input wire logic otp_lock_nv_in,
    // wishbone slave
    input wire fsir_pkg::fsir_wb_req_type wb_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // pins and status outputs
    output logic int_pin_out,
    output logic irq_out,
    output logic op_refused_out,
    output logic [1:0] main_ecc_result_out,
    output logic [1:0] spare_ecc_result_out
);

    if (ADR_W != 18)
    begin : g_adr_check
        $error("fsir_regs needs an 18-bit byte address");
    end

    // cold image of the master, load, prog, erase and reset flags
    localparam logic [15:0] INTF_COLD = `FSIR_INTF_COLD;
    localparam logic [4:0] INTF_COLD_BITS = {INTF_COLD[15],
        INTF_COLD[7:4]};

    fsir_pkg::fsir_state_type st_r, st_nxt;
    fsir_pkg::fsir_cls_type cls_r, cls_nxt, dec_cls;
    fsir_pkg::fsir_csw_type csw_r, csw_nxt;
    logic [1:0] ecc_m_r, ecc_m_nxt, ecc_s_r, ecc_s_nxt;
    logic refused_r, refused_nxt;
    logic otp_cap_r, otp_cap_nxt;
    logic any_rst;
    logic warm_rel;
    logic [4:0] cmpl;
    logic [4:0] intf_q, intf_set, intf_clr;
    logic [3:0] evt_q, evt_set, evt_clr;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic pol_r, pol_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic int_pin_r, irq_r;
    logic wr_fire;
    logic [15:0] idx;
    logic [15:0] intf_word;

    // command decode into an operation class
    always_comb
    begin
        case (op_in.cmd)
            `FSIR_CMD_LOAD_A, `FSIR_CMD_LOAD_B: dec_cls = fsir_pkg::CLS_LOAD;
            `FSIR_CMD_PROG_A, `FSIR_CMD_PROG_B,
            `FSIR_CMD_PROG_C: dec_cls = fsir_pkg::CLS_PROG;
            `FSIR_CMD_ERASE_A, `FSIR_CMD_ERASE_B,
            `FSIR_CMD_ERASE_C: dec_cls = fsir_pkg::CLS_ERASE;
            `FSIR_CMD_RST_A, `FSIR_CMD_RST_B,
            `FSIR_CMD_RST_C: dec_cls = fsir_pkg::CLS_RESET;
            `FSIR_CMD_MISC_A, `FSIR_CMD_MISC_B, `FSIR_CMD_MISC_C,
            `FSIR_CMD_MISC_D, `FSIR_CMD_MISC_E: dec_cls = fsir_pkg::CLS_MISC;
            default: dec_cls = fsir_pkg::CLS_NONE;
        endcase
        if (op_in.load_other)
        begin
            dec_cls = fsir_pkg::CLS_LOAD; // buffer load or boot
        end
    end

    assign any_rst = warm_rst_in | hot_rst_in;

    // controller status sequencing
    always_comb
    begin
        st_nxt = st_r;
        cls_nxt = cls_r;
        csw_nxt = csw_r;
        ecc_m_nxt = ecc_m_r;
        ecc_s_nxt = ecc_s_r;
        refused_nxt = 1'b0;
        otp_cap_nxt = 1'b1;
        warm_rel = 1'b0;
        cmpl = 5'b0_0000;
        case (st_r)
            fsir_pkg::ST_IDLE:
            begin
                if (any_rst)
                begin
                    csw_nxt = '0;
                    csw_nxt.otp_lock_flag = csw_r.otp_lock_flag;
                    csw_nxt.ongo = 1'b1;
                    csw_nxt.reset_busy_flag = 1'b1;
                    st_nxt = fsir_pkg::ST_RESETTING;
                end
                else if (op_in.start && dec_cls != fsir_pkg::CLS_NONE)
                begin
                    csw_nxt = '0;
                    csw_nxt.otp_lock_flag = csw_r.otp_lock_flag;
                    csw_nxt.load = (dec_cls == fsir_pkg::CLS_LOAD);
                    csw_nxt.prog = (dec_cls == fsir_pkg::CLS_PROG);
                    csw_nxt.erase = (dec_cls == fsir_pkg::CLS_ERASE);
                    csw_nxt.reset_busy_flag = (dec_cls == fsir_pkg::CLS_RESET);
                    cls_nxt = dec_cls;
                    if ((csw_nxt.prog || csw_nxt.erase) && op_in.otp_target
                        && csw_r.otp_lock_flag)
                    begin
                        csw_nxt.lock = 1'b1;
                        csw_nxt.error = 1'b1;
                        refused_nxt = 1'b1;
                    end
                    else
                    begin
                        csw_nxt.ongo = 1'b1;
                        st_nxt = fsir_pkg::ST_BUSY;
                    end
                end
            end
            fsir_pkg::ST_BUSY:
            begin
                csw_nxt.sus = op_in.suspend && cls_r == fsir_pkg::CLS_ERASE;
                if (any_rst)
                begin
                    csw_nxt.ongo = 1'b0;
                    csw_nxt.reset_busy_flag = 1'b1;
                    csw_nxt.error = csw_r.load | csw_r.prog | csw_r.erase;
                    if (cls_r == fsir_pkg::CLS_LOAD)
                    begin
                        ecc_m_nxt = `FSIR_ECC_NONE;
                        ecc_s_nxt = `FSIR_ECC_NONE;
                    end
                    st_nxt = fsir_pkg::ST_RESETTING;
                end
                else if (op_in.done)
                begin
                    csw_nxt.ongo = 1'b0;
                    csw_nxt.sus = 1'b0;
                    cmpl[cls_r == fsir_pkg::CLS_LOAD ? 4 :
                         cls_r == fsir_pkg::CLS_PROG ? 3 :
                         cls_r == fsir_pkg::CLS_ERASE ? 2 :
                         cls_r == fsir_pkg::CLS_RESET ? 1 : 0] = 1'b1;
                    if (op_in.fail && cls_r != fsir_pkg::CLS_RESET)
                    begin
                        csw_nxt.error = 1'b1;
                        if (cls_r == fsir_pkg::CLS_LOAD && op_in.ecc_main_bad)
                        begin
                            ecc_m_nxt = `FSIR_ECC_UNCORR;
                        end
                        if (cls_r == fsir_pkg::CLS_LOAD && op_in.ecc_spare_bad)
                        begin
                            ecc_s_nxt = `FSIR_ECC_UNCORR;
                        end
                    end
                    else
                    begin
                        csw_nxt = '0;
                        csw_nxt.otp_lock_flag = csw_r.otp_lock_flag;
                    end
                    st_nxt = fsir_pkg::ST_IDLE;
                end
            end
            fsir_pkg::ST_RESETTING:
            begin
                if (!any_rst)
                begin
                    csw_nxt.ongo = 1'b0;
                    csw_nxt.reset_busy_flag = 1'b0;
                    warm_rel = 1'b1;
                    st_nxt = fsir_pkg::ST_IDLE;
                end
            end
            default: st_nxt = fsir_pkg::ST_IDLE;
        endcase
        if (!otp_cap_r)
        begin
            csw_nxt.otp_lock_flag = otp_lock_nv_in;
        end
        csw_nxt.rsvd8 = 1'b0;
        csw_nxt.rsvd = 5'b0_0000;
        csw_nxt.expiry_flag = 1'b0;
    end

    // controller status registers
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            st_r <= fsir_pkg::ST_IDLE;
            cls_r <= fsir_pkg::CLS_NONE;
            csw_r <= '0;
            ecc_m_r <= `FSIR_ECC_NONE;
            ecc_s_r <= `FSIR_ECC_NONE;
            refused_r <= 1'b0;
            otp_cap_r <= 1'b0;
        end
        else if (ce_in)
        begin
            st_r <= st_nxt;
            cls_r <= cls_nxt;
            csw_r <= csw_nxt;
            ecc_m_r <= ecc_m_nxt;
            ecc_s_r <= ecc_s_nxt;
            refused_r <= refused_nxt;
            otp_cap_r <= otp_cap_nxt;
        end
    end

    // bus decode, write strobe on the acknowledged edge
    assign idx = wb_in.adr[17:2];
    assign wr_fire = wb_in.cyc && wb_in.stb && wb_in.we && ack_r;

    // interrupt flag sets and host clears, order master,load,prog,erase,rst
    always_comb
    begin
        intf_set[3:1] = cmpl[4:2];
        intf_set[0] = cmpl[1] | warm_rel;
        intf_set[4] = |intf_set[3:0] | cmpl[0];
        intf_clr = 5'b0_0000;
        if (wr_fire && idx == `FSIR_IDX_INTF)
        begin
            intf_clr[4] = wb_in.sel[1] && !wb_in.dat[`FSIR_INTF_MASTER];
            intf_clr[3] = wb_in.sel[0] && !wb_in.dat[`FSIR_INTF_LOAD];
            intf_clr[2] = wb_in.sel[0] && !wb_in.dat[`FSIR_INTF_PROG];
            intf_clr[1] = wb_in.sel[0] && !wb_in.dat[`FSIR_INTF_ERASE];
            intf_clr[0] = wb_in.sel[0] && !wb_in.dat[`FSIR_INTF_RST];
        end
        evt_set = {warm_rel, refused_nxt, |cmpl && csw_nxt.error,
                   |cmpl && !csw_nxt.error};
        evt_clr = 4'h0;
        if (wr_fire && idx == `FSIR_IDX_EVT && wb_in.sel[0])
        begin
            evt_clr = wb_in.dat[3:0];
        end
    end

    // interrupt flags; warm or hot reset clears all but the reset flag
    genvar gi;
    for (gi = 0; gi < 5; gi++)
    begin : g_intf
        fsir_flag #(
            .COLD_VAL(INTF_COLD_BITS[gi])
        ) u_flag (
            .clk_in(ref_clk_in),
            .rst_b_in(rst_b_in),
            .ce_in(ce_in),
            .set_in(intf_set[gi]),
            .clr_in(intf_clr[gi]),
            .load_in(any_rst && gi != 0),
            .load_val_in(1'b0),
            .q_out(intf_q[gi])
        );
    end

    // event flags for the system interrupt, cleared by writing one
    for (gi = 0; gi < 4; gi++)
    begin : g_evt
        fsir_flag #(
            .COLD_VAL(1'b0)
        ) u_flag (
            .clk_in(ref_clk_in),
            .rst_b_in(rst_b_in),
            .ce_in(ce_in),
            .set_in(evt_set[gi]),
            .clr_in(evt_clr[gi]),
            .load_in(1'b0),
            .load_val_in(1'b0),
            .q_out(evt_q[gi])
        );
    end

    assign intf_word = {intf_q[4], 7'h00, intf_q[3:0], 4'h0};

    // bus slave, config and mask next values
    always_comb
    begin
        ack_nxt = wb_in.cyc && wb_in.stb && !ack_r;
        dat_nxt = 32'h0000_0000;
        case (idx)
            `FSIR_IDX_CSW: dat_nxt[15:0] = csw_r;
            `FSIR_IDX_INTF: dat_nxt[15:0] = intf_word;
            `FSIR_IDX_CFG: dat_nxt[0] = pol_r;
            `FSIR_IDX_EVT: dat_nxt[3:0] = evt_q;
            `FSIR_IDX_MASK: dat_nxt[3:0] = mask_r;
            default: dat_nxt = 32'h0000_0000;
        endcase
        pol_nxt = pol_r;
        mask_nxt = mask_r;
        if (wr_fire && wb_in.sel[0] && idx == `FSIR_IDX_CFG)
        begin
            pol_nxt = wb_in.dat[0];
        end
        if (wr_fire && wb_in.sel[0] && idx == `FSIR_IDX_MASK)
        begin
            mask_nxt = wb_in.dat[3:0];
        end
    end

    // bus and pin registers
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_b_in)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            pol_r <= 1'b1;
            mask_r <= `FSIR_MASK_RESET;
            int_pin_r <= 1'b1;
            irq_r <= 1'b0;
        end
        else if (ce_in)
        begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            pol_r <= pol_nxt;
            mask_r <= mask_nxt;
            int_pin_r <= pol_r ? intf_q[4] : !intf_q[4];
            irq_r <= |(evt_q & mask_r);
        end
    end

    assign wb_ack_out = ack_r;
    assign wb_dat_out = dat_r;
    assign int_pin_out = int_pin_r;
    assign irq_out = irq_r;
    assign op_refused_out = refused_r;
    assign main_ecc_result_out = ecc_m_r;
    assign spare_ecc_result_out = ecc_s_r;

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_RESET_BUSY_FLAG_HELD: assert property (st_r == fsir_pkg::ST_RESETTING
        |-> csw_r.reset_busy_flag) else $error("reset-busy low in reset");
    AST_RESET_BUSY_FLAG_IDLE: assert property (st_r == fsir_pkg::ST_IDLE
        |-> !csw_r.reset_busy_flag) else $error("reset-busy high at idle");
    AST_OTP_CAPTURE: assert property ($rose(otp_cap_r)
        |-> csw_r.otp_lock_flag == $past(otp_lock_nv_in))
        else $error("otp lock not captured");
    AST_OTP_STABLE: assert property (otp_cap_r && $past(otp_cap_r)
        |-> $stable(csw_r.otp_lock_flag)) else $error("otp lock moved");
    AST_OTP_REFUSE: assert property (ce_in && st_r == fsir_pkg::ST_IDLE
        && !any_rst && op_in.start && op_in.otp_target && otp_cap_r
        && csw_r.otp_lock_flag && (dec_cls == fsir_pkg::CLS_PROG
        || dec_cls == fsir_pkg::CLS_ERASE) |=> op_refused_out && csw_r.lock
        && csw_r.error && !csw_r.ongo ##1 !op_refused_out)
        else $error("locked otp operation not refused");
    AST_EXPIRY: assert property (csw_r.expiry_flag == 1'b0
        && csw_r.rsvd == 5'b0_0000) else $error("expiry bit set");
    AST_OP_OK: assert property (ce_in && st_r == fsir_pkg::ST_BUSY
        && !any_rst && op_in.done && !op_in.fail
        |=> !csw_r.ongo && csw_r[13:10] == 4'h0) else $error("ok not clean");
    AST_OP_FAIL: assert property (ce_in && st_r == fsir_pkg::ST_BUSY
        && !any_rst && op_in.done && op_in.fail && cls_r == fsir_pkg::CLS_PROG
        |=> csw_r.prog && csw_r.error && !csw_r.ongo)
        else $error("program fail not reported");
    AST_LOAD_FAIL: assert property (ce_in && st_r == fsir_pkg::ST_BUSY
        && cls_r == fsir_pkg::CLS_LOAD && !any_rst && op_in.done
        && op_in.fail && op_in.ecc_main_bad |=> csw_r.load && csw_r.error
        && main_ecc_result_out == `FSIR_ECC_UNCORR)
        else $error("load fail ecc code wrong");
    AST_LOAD_ABORT: assert property (ce_in && st_r == fsir_pkg::ST_BUSY
        && cls_r == fsir_pkg::CLS_LOAD && any_rst |=> csw_r.load
        && csw_r.error && csw_r.reset_busy_flag && main_ecc_result_out == 2'h0
        && spare_ecc_result_out == 2'h0) else $error("load abort wrong");
    AST_PIN: assert property (ce_in && $past(ce_in) |=> int_pin_out ==
        ($past(pol_r) ? $past(intf_q[4]) : !$past(intf_q[4])))
        else $error("interrupt pin wrong");
    AST_WARM_VAL: assert property (ce_in
        && st_r == fsir_pkg::ST_RESETTING && !any_rst
        |=> intf_word == `FSIR_INTF_WARM) else $error("warm value wrong");
    AST_MASTER_SET: assert property (ce_in && (|cmpl)
        |=> intf_q[4]) else $error("master flag not set");
    AST_MASTER_CLR: assert property (ce_in && any_rst
        |=> !intf_q[4] ##1 !any_rst || !intf_q[4])
        else $error("master flag not cleared by reset");
    AST_LOAD_FLAG: assert property (ce_in && cmpl[4]
        |=> intf_q[3] && intf_q[4]) else $error("load flag not set");
    AST_PROG_FLAG: assert property (ce_in && cmpl[3]
        |=> intf_q[2]) else $error("program flag not set");
    AST_ERASE_FLAG: assert property (ce_in && cmpl[2]
        |=> intf_q[1]) else $error("erase flag not set");
    AST_RST_FLAG_HOLD: assert property (ce_in && intf_q[0] && any_rst
        && !intf_clr[0] |=> intf_q[0])
        else $error("reset flag cleared by reset");

    COV_LOAD_OK: cover property (st_r == fsir_pkg::ST_BUSY
        && cls_r == fsir_pkg::CLS_LOAD ##1 intf_q[3]);
    COV_REFUSE: cover property (op_refused_out);
    COV_LOAD_ABORT: cover property (csw_r.load && csw_r.reset_busy_flag);
    COV_IRQ: cover property ($rose(irq_out));

endmodule : fsir_regs

// [verification/fsir_host.sv]
// Purpose: host processor model, classic wishbone master
// Assumes: slave acks each single cycle
// Notes:   waits for ack as long as it takes; the bench timeout ends a hang
module fsir_host (
    // clock and slave answer
    input wire logic clk_in,
    input wire logic ack_in,
    input wire logic [31:0] dat_in,
    // request
    output fsir_pkg::fsir_wb_req_type wb_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial wb_out = '0;

    // one single cycle, held until ack is sampled
    task automatic xfer(input logic we, input logic [15:0] idx,
        input logic [15:0] wd, output logic [15:0] rd);
        @(posedge clk_in);
        wb_out <= {2'h3, we, idx, 2'h0, 4'h3, 16'h0000, wd};
        do
        begin
            @(posedge clk_in);
        end
        while (ack_in !== 1'h1);
        rd = dat_in[15:0];
        wb_out.cyc <= 1'h0;
        wb_out.stb <= 1'h0;
        wb_out.dat <= ~wb_out.dat; // released data no longer valid
    endtask : xfer
endmodule : fsir_host

// [verification/fsir_regs_test.sv]
// Purpose: self-checking bench of the status and interrupt registers
// Assumes: clock 100 MHz, cold reset active low
// Notes:   host model issues all bus cycles
`include "fsir_defs.svh"
module fsir_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic warm_rst_in = 1'h0;
    logic hot_rst_in = 1'h0;
    logic ce_in = 1'h1;
    logic otp_lock_nv_in = 1'h0;
    fsir_pkg::fsir_op_type op_in = '0;
    fsir_pkg::fsir_wb_req_type wb_in;
    logic [31:0] wb_dat_out;
    logic wb_ack_out, int_pin_out, irq_out, op_refused_out;
    logic [1:0] main_ecc, spare_ecc;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] cmds [16] = '{16'h0000, 16'h0013, 16'h0080, 16'h001A,
        16'h001B, 16'h0094, 16'h0095, 16'h0030, 16'h00B0, 16'h00F0,
        16'h00F3, 16'h0065, 16'h0023, 16'h0071, 16'h002A, 16'h002C};
    logic [7:0] flags [16] = '{8'h80, 8'h80, 8'h40, 8'h40, 8'h40, 8'h20,
        8'h20, 8'h20, 8'h10, 8'h10, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00};

    // clock
    initial forever #5 ref_clk_in = ~ref_clk_in;

    // design and host
    fsir_regs DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .ce_in(ce_in), .warm_rst_in(warm_rst_in), .hot_rst_in(hot_rst_in),
        .op_in(op_in), .otp_lock_nv_in(otp_lock_nv_in), .wb_in(wb_in),
        .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .int_pin_out(int_pin_out), .irq_out(irq_out),
        .op_refused_out(op_refused_out), .main_ecc_result_out(main_ecc),
        .spare_ecc_result_out(spare_ecc));
    fsir_host HOST (.clk_in(ref_clk_in), .ack_in(wb_ack_out),
        .dat_in(wb_dat_out), .wb_out(wb_in));

    task automatic finish_test();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] idx, input logic [15:0] exp);
        logic [15:0] d;
        HOST.xfer(1'h0, idx, 16'h0000, d);
        chk(d, exp);
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [15:0] v);
        logic [15:0] d;
        HOST.xfer(1'h1, idx, v, d);
    endtask : wr

    task automatic op_go(input logic [15:0] cmd, input logic otp);
        @(posedge ref_clk_in);
        op_in.start <= 1'h1;
        op_in.cmd <= cmd;
        op_in.otp_target <= otp;
        @(posedge ref_clk_in);
        op_in.start <= 1'h0;
    endtask : op_go

    task automatic op_end(input logic fail, input logic bad);
        @(posedge ref_clk_in);
        op_in.done <= 1'h1;
        op_in.fail <= fail;
        op_in.ecc_main_bad <= bad;
        op_in.ecc_spare_bad <= bad;
        @(posedge ref_clk_in);
        op_in.done <= 1'h0;
        op_in.fail <= 1'h0;
        op_in.ecc_main_bad <= 1'h0;
        op_in.ecc_spare_bad <= 1'h0;
        @(posedge ref_clk_in);
    endtask : op_end

    task automatic cold(input logic nv);
        otp_lock_nv_in <= nv;
        rst_b_in <= 1'h0;
        repeat (8) @(posedge ref_clk_in);
        rst_b_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
    endtask : cold

    task automatic test_reset();
        rd(`FSIR_IDX_CSW, 16'h0000);
        rd(`FSIR_IDX_INTF, 16'h8080);
        rd(`FSIR_IDX_CFG, 16'h0001);
        rd(`FSIR_IDX_MASK, 16'h0000);
        wr(16'hF243, 16'hFFFF);
        rd(16'hF243, 16'h0000);
        ce_in <= 1'h0;
        warm_rst_in <= 1'h1;
        repeat (3) @(posedge ref_clk_in);
        warm_rst_in <= 1'h0;
        ce_in <= 1'h1;
        rd(`FSIR_IDX_INTF, 16'h8080);
        chk({15'h0, int_pin_out}, 16'h0001);
    endtask : test_reset

    task automatic test_ops();
        logic [15:0] busy;
        wr(`FSIR_IDX_MASK, 16'h0001);
        for (int i = 0; i < 16; i++)
        begin
            wr(`FSIR_IDX_INTF, 16'h0000);
            op_go(cmds[i], 1'h0);
            case (flags[i])
                8'h80: busy = 16'hA000;
                8'h40: busy = 16'h9000;
                8'h20: busy = 16'h8800;
                default: busy = 16'h8080;
            endcase
            if (flags[i] != 8'h00)
                rd(`FSIR_IDX_CSW, busy);
            op_end(1'h0, 1'h0);
            rd(`FSIR_IDX_INTF, {8'h80, flags[i]});
            rd(`FSIR_IDX_CSW, 16'h0000);
        end
        chk({15'h0, irq_out}, 16'h0001);
        rd(`FSIR_IDX_EVT, 16'h0001);
        wr(`FSIR_IDX_EVT, 16'h0001);
        repeat (2) @(posedge ref_clk_in);
        chk({15'h0, irq_out}, 16'h0000);
        wr(`FSIR_IDX_INTF, 16'h0000);
        repeat (2) @(posedge ref_clk_in);
        chk({15'h0, int_pin_out}, 16'h0000);
        wr(`FSIR_IDX_CFG, 16'h0000);
        repeat (2) @(posedge ref_clk_in);
        chk({15'h0, int_pin_out}, 16'h0001);
        wr(`FSIR_IDX_CFG, 16'h0001);
    endtask : test_ops

    task automatic test_fail_warm();
        op_go(16'h0013, 1'h0);
        op_end(1'h1, 1'h1);
        rd(`FSIR_IDX_CSW, 16'h2400);
        chk({14'h0, main_ecc}, 16'h0002);
        chk({14'h0, spare_ecc}, 16'h0002);
        op_go(16'h0000, 1'h0);
        warm_rst_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        rd(`FSIR_IDX_CSW, 16'h2480);
        chk({14'h0, main_ecc}, 16'h0000);
        chk({14'h0, spare_ecc}, 16'h0000);
        @(posedge ref_clk_in);
        warm_rst_in <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        rd(`FSIR_IDX_INTF, 16'h8010);
        rd(`FSIR_IDX_CSW, 16'h2400);
    endtask : test_fail_warm

    task automatic test_otp();
        cold(1'h1);
        rd(`FSIR_IDX_CSW, 16'h0040);
        op_go(16'h0080, 1'h1);
        @(posedge ref_clk_in);
        chk({15'h0, op_refused_out}, 16'h0001);
        rd(`FSIR_IDX_CSW, 16'h5440);
        rd(`FSIR_IDX_INTF, 16'h8080);
        hot_rst_in <= 1'h1;
        repeat (2) @(posedge ref_clk_in);
        hot_rst_in <= 1'h0;
        repeat (2) @(posedge ref_clk_in);
        rd(`FSIR_IDX_INTF, 16'h8010);
        op_in.load_other <= 1'h1;
        op_go(16'h00E0, 1'h0);
        op_in.load_other <= 1'h0;
        op_end(1'h0, 1'h0);
        rd(`FSIR_IDX_INTF, 16'h8090);
    endtask : test_otp

    // main sequence
    initial
    begin
        cold(1'h0);
        test_reset();
        test_ops();
        test_fail_warm();
        test_otp();
        finish_test();
    end

    // hang guard
    always @(posedge ref_clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            finish_test();
        end
    end
endmodule : fsir_regs_test
